// File: common/ufm_pkg.sv
// Purpose: shared constants of the serial controller register bank
// Assumes: 8-bit parallel host bus, 125 MHz sys_clk
// Notes:   offsets are byte addresses on the parallel bus
package ufm_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_CHAN_STATUS   = 8'hE0;
    localparam logic [7:0] ADDR_CLOCK_PERIOD  = 8'hEB;
    localparam logic [7:0] ADDR_DATA_DELAY    = 8'hEC;
    localparam logic [7:0] ADDR_MODE_CONTROL  = 8'hED;
    localparam logic [7:0] ADDR_CHAN_RESET    = 8'hEF;
    localparam logic [7:0] ADDR_CTRL_STATUS   = 8'hF0;
    localparam logic [7:0] ADDR_CTRL_IRQ_MASK = 8'hF1;
    localparam logic [7:0] ADDR_PART_ID       = 8'hF6;
    localparam logic [7:0] ADDR_GLOBAL_RESET  = 8'hF7;
    localparam logic [7:0] ADDR_CTRL_READY    = 8'hFF;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_CHANNEL_ON    = 7;
    localparam int BIT_BUFFER_FAULT  = 7;
    localparam int BIT_CHAN_ACTIVE   = 5;
    localparam int BIT_CHAN_IRQ      = 2;
    localparam int BIT_FAULT_MASK    = 7;
    localparam int BIT_CHAN_MASK     = 2;
    localparam int BIT_FAMILY        = 7;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [7:0] RST_CLOCK_PERIOD  = 8'h20;
    localparam logic [5:0] RST_DATA_DELAY    = 6'h08;
    localparam logic       RST_CHANNEL_ON    = 1'b1;
    localparam logic [1:0] TIMING_CLASS_UFM  = 2'h3;
    localparam logic [7:0] RST_IRQ_MASK      = 8'h00;
    localparam logic [7:0] KEY_FIRST         = 8'hA5;
    localparam logic [7:0] KEY_SECOND        = 8'h5A;
    localparam logic [7:0] READ_BUSY         = 8'hFF;
    localparam logic [7:0] READ_IDLE         = 8'h00;
    // identity values are arbitrary
    localparam logic       ID_FAMILY         = 1'b0;
    localparam logic [6:0] ID_PART_BCD       = 7'h12;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ          = 125;
    localparam int INIT_TIME_US     = 100;
    localparam int INIT_CYCLES      = INIT_TIME_US * CLK_MHZ;
    localparam int CHRST_TIME_NS    = 200;
    localparam int CHRST_CYCLES     = (CHRST_TIME_NS * CLK_MHZ + 999) / 1000;

    // ************************************************************
    // controller phase
    // ************************************************************
    typedef enum logic [2:0] {
        PH_INIT  = 3'b001,
        PH_RUN   = 3'b010,
        PH_CHRST = 3'b100
    } ufm_phase_type;

endpackage : ufm_pkg

// File: src/ufm_sclk_gen.sv
// Purpose: serial clock and delayed data generator
// Assumes: period and delay settings stable while running
// Notes:   clock and data idle high when not running
module ufm_sclk_gen
    import ufm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [7:0] period,
    input  wire logic [5:0] delay,
    input  wire logic       tx_bit,
    output logic            sclk_q,
    output logic            sdat_q
);

    logic [6:0] half;
    logic [6:0] half_use;
    logic [6:0] cnt_q;
    logic [5:0] dcnt_q;
    logic       wrap;
    logic       fall;

    // ************************************************************
    // half period and edges
    // ************************************************************
    assign half     = period[7:1];
    assign half_use = (half == 7'h00) ? 7'h01 : half;
    assign wrap     = (cnt_q >= half_use - 7'h01);
    assign fall     = run && wrap && sclk_q;

    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            cnt_q  <= 7'h00;
            sclk_q <= 1'b1;
        end else if (wrap) begin
            cnt_q  <= 7'h00;
            sclk_q <= ~sclk_q;
        end else begin
            cnt_q  <= cnt_q + 7'h01;
        end
    end

    // ************************************************************
    // data delayed after falling clock edge
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            dcnt_q <= 6'h00;
            sdat_q <= 1'b1;
        end else if (fall) begin
            dcnt_q <= delay;
        end else if (dcnt_q != 6'h00) begin
            dcnt_q <= dcnt_q - 6'h01;
            if (dcnt_q == 6'h01) begin
                sdat_q <= tx_bit;
            end
        end
    end

endmodule : ufm_sclk_gen

// File: src/ufm_regs_top.sv
// Purpose: host register bank of the ultra fast-mode serial controller
// Assumes: asynchronous parallel bus pins, synchronised here
// Notes:   transfer engine and buffer live outside this block
// Notes on behaviour
// - serial clock runs 50 % duty, half period is setting shifted right once
// - writing clock period loads data delay with period shifted right twice
// - channel off floats open-drain lines, drives push-pull high, refuses launch
// - channel on bit reads 1 after reset
// - timing class field is read-only, always reads 11
// - channel reset needs A5h then 5Ah back to back, else aborted
// - channel reset returns channel registers and arrays to defaults
// - bus usable during channel reset; key register reads FFh busy, 00h done
// - controller status: fault bit 7, active bit 5, irq pending bit 2
// - channel irq pending cleared by reading channel status register
// - buffer fault cleared by reading controller status register
// - out-of-range buffer access flags fault, bytes beyond capacity dropped
// - mask bit 2 hides channel interrupts, mask bit 7 hides fault
// - identifier: family bit 7, part code bits 6:0
// - global reset needs A5h then 5Ah back to back, resets everything except the bus interface registers and data_out
// - ready reads FFh while initialising, 00h afterwards
// - period 8 bits default 32; delay 6 bits default 8, upper bits zero
module ufm_regs_top
    import ufm_pkg::*;
#(
    parameter int INIT_CYC = INIT_CYCLES
)
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       ce_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic            int_n,
    input  wire logic       chan_busy,
    input  wire logic       chan_irq_event,
    input  wire logic [7:0] chan_status_val,
    input  wire logic       buf_access,
    input  wire logic       buf_access_ok,
    output logic            buf_write_keep,
    input  wire logic       launch_req,
    output logic            launch_ok,
    input  wire logic       tx_bit,
    output logic            chan_reset,
    output logic            pushpull_clock_line,
    output logic            pushpull_data_line,
    output logic            od_clock_out,
    output logic            od_clock_oe,
    output logic            od_data_out,
    output logic            od_data_oe
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [18:0]   pin_meta_q;
    logic [18:0]   pin_sync_q;
    logic          ce_s;
    logic          rd_s;
    logic          wr_s;
    logic [7:0]    addr_s;
    logic [7:0]    din_s;
    logic          rd_act_q;
    logic          wr_act_q;

    always_ff @(posedge sys_clk) begin
        pin_meta_q <= {ce_n, rd_n, wr_n, addr, data_in};
        pin_sync_q <= pin_meta_q;
    end

    assign ce_s   = ~pin_sync_q[18];
    assign rd_s   = ~pin_sync_q[17];
    assign wr_s   = ~pin_sync_q[16];
    assign addr_s = pin_sync_q[15:8];
    assign din_s  = pin_sync_q[7:0];

    // ************************************************************
    // access strobes
    // ************************************************************
    logic rd_now;
    logic wr_now;
    logic rd_end;
    logic wr_end;
    logic acc_end;

    assign rd_now  = ce_s && rd_s;
    assign wr_now  = ce_s && wr_s;
    assign rd_end  = rd_act_q && !rd_now;
    assign wr_end  = wr_act_q && !wr_now;
    assign acc_end = rd_end || wr_end;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            rd_act_q <= rd_now;
            wr_act_q <= wr_now;
        end
    end

    // ************************************************************
    // registered address and data of the access in progress
    // ************************************************************
    logic [7:0] acc_addr_q;
    logic [7:0] acc_data_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_addr_q <= 8'h00;
            acc_data_q <= 8'h00;
        end else if (rd_now || wr_now) begin
            acc_addr_q <= addr_s;
            acc_data_q <= din_s;
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    // ************************************************************
    // two-step key tracking
    // ************************************************************
    logic gkey_armed_q;
    logic ckey_armed_q;
    logic gfire;
    logic cfire;
    logic grst_q;
    logic soft_rst;

    assign gfire = wr_end && gkey_armed_q
                && hit(acc_addr_q, ADDR_GLOBAL_RESET) && acc_data_q == KEY_SECOND;
    assign cfire = wr_end && ckey_armed_q
                && hit(acc_addr_q, ADDR_CHAN_RESET) && acc_data_q == KEY_SECOND;
    assign soft_rst = rst || grst_q;

    always_ff @(posedge sys_clk) begin
        if (soft_rst) begin
            gkey_armed_q <= 1'b0;
            ckey_armed_q <= 1'b0;
        end else if (acc_end) begin
            gkey_armed_q <= wr_end && hit(acc_addr_q, ADDR_GLOBAL_RESET)
                         && acc_data_q == KEY_FIRST;
            ckey_armed_q <= wr_end && hit(acc_addr_q, ADDR_CHAN_RESET)
                         && acc_data_q == KEY_FIRST;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            grst_q <= 1'b0;
        end else begin
            grst_q <= gfire;
        end
    end

    // ************************************************************
    // controller phase and counters
    // ************************************************************
    ufm_phase_type phase_q;
    ufm_phase_type phase_d;
    logic [15:0]   init_cnt_q;
    logic [7:0]    chrst_cnt_q;
    logic          chan_clear;

    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            PH_INIT: begin
                if (init_cnt_q >= 16'(INIT_CYC - 1)) begin
                    phase_d = PH_RUN;
                end
            end
            PH_RUN: begin
                if (cfire) begin
                    phase_d = PH_CHRST;
                end
            end
            PH_CHRST: begin
                if (chrst_cnt_q >= 8'(CHRST_CYCLES - 1)) begin
                    phase_d = PH_RUN;
                end
            end
            default: begin
                phase_d = PH_INIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (soft_rst) begin
            phase_q     <= PH_INIT;
            init_cnt_q  <= 16'h0000;
            chrst_cnt_q <= 8'h00;
        end else begin
            phase_q     <= phase_d;
            init_cnt_q  <= (phase_q == PH_INIT) ? init_cnt_q + 16'h0001 : 16'h0000;
            chrst_cnt_q <= (phase_q == PH_CHRST) ? chrst_cnt_q + 8'h01 : 8'h00;
        end
    end

    assign chan_clear = soft_rst || cfire;
    assign chan_reset = (phase_q == PH_CHRST);

    // ************************************************************
    // channel settings
    // ************************************************************
    logic [7:0] period_q;
    logic [5:0] delay_q;
    logic       chan_on_q;
    logic       wr_period;
    logic       wr_delay;
    logic       wr_mode;
    logic       wr_mask;

    assign wr_period = wr_end && hit(acc_addr_q, ADDR_CLOCK_PERIOD);
    assign wr_delay  = wr_end && hit(acc_addr_q, ADDR_DATA_DELAY);
    assign wr_mode   = wr_end && hit(acc_addr_q, ADDR_MODE_CONTROL);
    assign wr_mask   = wr_end && hit(acc_addr_q, ADDR_CTRL_IRQ_MASK);

    always_ff @(posedge sys_clk) begin
        if (chan_clear) begin
            period_q  <= RST_CLOCK_PERIOD;
            delay_q   <= RST_DATA_DELAY;
            chan_on_q <= RST_CHANNEL_ON;
        end else begin
            if (wr_period) begin
                period_q <= acc_data_q;
                delay_q  <= acc_data_q[7:2];
            end else if (wr_delay) begin
                delay_q  <= acc_data_q[5:0];
            end
            if (wr_mode) begin
                chan_on_q <= acc_data_q[BIT_CHANNEL_ON];
            end
        end
    end

    // ************************************************************
    // status, mask and interrupt
    // ************************************************************
    logic [7:0] mask_q;
    logic       fault_q;
    logic       chan_irq_q;
    logic       fault_event;
    logic       rd_ctrl_status;
    logic       rd_chan_status;

    assign fault_event    = buf_access && !buf_access_ok;
    assign buf_write_keep = buf_access_ok;
    assign rd_ctrl_status = rd_end && hit(acc_addr_q, ADDR_CTRL_STATUS);
    assign rd_chan_status = rd_end && hit(acc_addr_q, ADDR_CHAN_STATUS);

    always_ff @(posedge sys_clk) begin
        if (soft_rst) begin
            mask_q     <= RST_IRQ_MASK;
            fault_q    <= 1'b0;
            chan_irq_q <= 1'b0;
            int_n      <= 1'b1;
        end else begin
            if (wr_mask) begin
                mask_q <= acc_data_q;
            end
            fault_q    <= fault_event || (fault_q && !rd_ctrl_status);
            chan_irq_q <= chan_irq_event || (chan_irq_q && !rd_chan_status && !cfire);
            int_n      <= !((fault_q && !mask_q[BIT_FAULT_MASK])
                         || (chan_irq_q && !mask_q[BIT_CHAN_MASK]));
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    logic [7:0] status_val;
    logic [7:0] mode_val;
    logic [7:0] rd_mux;

    assign status_val = {fault_q, 1'b0, chan_busy, 2'b00, chan_irq_q, 2'b00};
    assign mode_val   = {chan_on_q, 5'h00, TIMING_CLASS_UFM};

    always_comb begin
        case (addr_s)
            ADDR_CHAN_STATUS:   rd_mux = chan_status_val;
            ADDR_CLOCK_PERIOD:  rd_mux = period_q;
            ADDR_DATA_DELAY:    rd_mux = {2'b00, delay_q};
            ADDR_MODE_CONTROL:  rd_mux = mode_val;
            ADDR_CHAN_RESET:    rd_mux = chan_reset ? READ_BUSY : READ_IDLE;
            ADDR_CTRL_STATUS:   rd_mux = status_val;
            ADDR_CTRL_IRQ_MASK: rd_mux = mask_q;
            ADDR_PART_ID:       rd_mux = {ID_FAMILY, ID_PART_BCD};
            ADDR_CTRL_READY:    rd_mux = (phase_q == PH_INIT) ? READ_BUSY : READ_IDLE;
            default:            rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_out <= 8'h00;
        end else if (rd_now) begin
            data_out <= rd_mux;
        end
    end

    assign data_oe = rd_now && rd_act_q;

    // ************************************************************
    // serial lines
    // ************************************************************
    logic run;
    logic sclk;
    logic sdat;

    assign run = chan_on_q && !chan_reset && (phase_q == PH_RUN);

    ufm_sclk_gen u_sclk_gen (
        .sys_clk (sys_clk),
        .rst     (soft_rst),
        .run     (run),
        .period  (period_q),
        .delay   (delay_q),
        .tx_bit  (tx_bit),
        .sclk_q  (sclk),
        .sdat_q  (sdat)
    );

    assign launch_ok           = launch_req && run;
    assign pushpull_clock_line = sclk;
    assign pushpull_data_line  = sdat;
    assign od_clock_out        = 1'b0;
    assign od_data_out         = 1'b0;
    assign od_clock_oe         = run && !sclk;
    assign od_data_oe          = run && !sdat;

endmodule : ufm_regs_top

// File: bench/ufm_regs_chk.sv
// Purpose: port-level checker of the register bank
// Assumes: single sys_clk domain, rst synchronous high
// Notes:   bound from the testbench top file
module ufm_regs_chk (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       ce_n,
    input wire logic       rd_n,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       int_n,
    input wire logic       buf_access,
    input wire logic       buf_access_ok,
    input wire logic       buf_write_keep,
    input wire logic       launch_req,
    input wire logic       launch_ok,
    input wire logic       chan_reset,
    input wire logic       pushpull_clock_line,
    input wire logic       pushpull_data_line,
    input wire logic       od_clock_out,
    input wire logic       od_clock_oe,
    input wire logic       od_data_out,
    input wire logic       od_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_od_low; !od_clock_out && !od_data_out; endproperty
    property p_launch; launch_ok |-> launch_req; endproperty
    property p_rst_idle;
        $fell(rst) |-> int_n && pushpull_clock_line && pushpull_data_line
            && !od_clock_oe && !od_data_oe && data_out == 8'h00;
    endproperty
    property p_chrst_min; $rose(chan_reset) |-> chan_reset[*8]; endproperty
    property p_chrst_max; $rose(chan_reset) |-> ##[1:30] !chan_reset; endproperty
    property p_keep; buf_access && !buf_access_ok |-> !buf_write_keep; endproperty
    property p_oe; !ce_n && !rd_n && !$past(ce_n, 3) && !$past(rd_n, 3) |-> data_oe; endproperty
    property p_oe_off;
        rd_n && $past(rd_n, 1) && $past(rd_n, 2) && $past(rd_n, 3) |-> !data_oe;
    endproperty
    a_od_low: assert property (p_od_low) else $error("open-drain level not low");
    a_launch: assert property (p_launch) else $error("launch without request");
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle");
    a_chrst_min: assert property (p_chrst_min) else $error("channel reset too short");
    a_chrst_max: assert property (p_chrst_max) else $error("channel reset stuck");
    a_keep: assert property (p_keep) else $error("bad buffer write kept");
    a_oe: assert property (p_oe) else $error("read data not driven");
    a_oe_off: assert property (p_oe_off) else $error("bus driven when idle");
    c_chrst: cover property ($rose(chan_reset));
    c_irq: cover property ($fell(int_n));
    c_fault: cover property (buf_access && !buf_access_ok);
endmodule : ufm_regs_chk

// File: bench/ufm_host_model.sv
// Purpose: host cpu model on the parallel bus
// Assumes: strobes held low and high 5 cycles each
// Notes:   released address and data show inverted values
module ufm_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] data_out,
    output logic            ce_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [7:0] addr,
    output logic      [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ce_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 8'h00;
        data_in = 8'h00;
    end
    // one access; ce toggles with every strobe
    task bus_access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
        @(negedge sys_clk);
        addr <= a;
        data_in <= d;
        ce_n <= 1'b0;
        wr_n <= !wr;
        rd_n <= wr;
        repeat (5) @(negedge sys_clk);
        q = data_out;
        ce_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        addr <= ~a;
        data_in <= ~d;
        repeat (5) @(negedge sys_clk);
    endtask : bus_access
endmodule : ufm_host_model

// File: bench/ufm_regs_top_tb.sv
// Purpose: self-checking bench of the register bank
// Assumes: host model drives the bus, bench drives channel side
// Notes:   init time shortened through INIT_CYC
module ufm_regs_top_tb;
    import ufm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT_N = 40;
    logic sys_clk, rst, ce_n, rd_n, wr_n, data_oe, int_n, chan_busy, chan_irq_event;
    logic buf_access, buf_access_ok, buf_write_keep, launch_req, launch_ok, chan_reset;
    logic pp_c, pp_d, odc, odc_oe, odd, odd_oe, tx_bit;
    logic [7:0] addr, data_in, data_out, chan_status_val;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    `define CMP(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
        $display("mismatch t=%0t got %h want %h", $time, g, e); end end
    ufm_regs_top #(.INIT_CYC(INIT_N)) dut_u (.sys_clk(sys_clk), .rst(rst), .ce_n(ce_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .int_n(int_n), .chan_busy(chan_busy),
        .chan_irq_event(chan_irq_event), .chan_status_val(chan_status_val),
        .buf_access(buf_access), .buf_access_ok(buf_access_ok),
        .buf_write_keep(buf_write_keep), .launch_req(launch_req), .launch_ok(launch_ok),
        .tx_bit(tx_bit), .chan_reset(chan_reset), .pushpull_clock_line(pp_c),
        .pushpull_data_line(pp_d), .od_clock_out(odc), .od_clock_oe(odc_oe),
        .od_data_out(odd), .od_data_oe(odd_oe));
    ufm_host_model host_u (.sys_clk(sys_clk), .data_out(data_out), .ce_n(ce_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host_u.bus_access(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        host_u.bus_access(1'b0, a, 8'h00, q);
        `CMP(q, e)
    endtask : rd
    // one-cycle channel event, then let int_n settle
    task ev(input logic irq, input logic bad);
        @(negedge sys_clk);
        chan_irq_event = irq;
        buf_access = bad;
        buf_access_ok = !bad;
        #1 `CMP(buf_write_keep, !bad)
        @(negedge sys_clk);
        chan_irq_event = 1'b0;
        buf_access = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask : ev
    task launch(input logic e);
        launch_req = 1'b1;
        #1 `CMP(launch_ok, e)
        `CMP({pp_c, pp_d, odc_oe, odd_oe}, 4'hC)
        @(negedge sys_clk);
        launch_req = 1'b0;
    endtask : launch
    logic [7:0] ra [8] = '{ADDR_CLOCK_PERIOD, ADDR_DATA_DELAY, ADDR_MODE_CONTROL,
        ADDR_CHAN_RESET, ADDR_CTRL_STATUS, ADDR_CTRL_IRQ_MASK, ADDR_PART_ID, 8'h00};
    logic [7:0] re [8] = '{8'h20, 8'h08, 8'h83, 8'h00, 8'h00, 8'h00,
        {ID_FAMILY, ID_PART_BCD}, 8'h00};
    initial begin
        rst = 1'b1;
        {chan_busy, chan_irq_event, buf_access, buf_access_ok, launch_req} = 5'h02;
        chan_status_val = 8'h5C;
        tx_bit = 1'b0;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        rd(ADDR_CTRL_READY, 8'hFF);
        repeat (INIT_N) @(negedge sys_clk);
        rd(ADDR_CTRL_READY, 8'h00);
        for (int i = 0; i < 8; i++) rd(ra[i], re[i]);
        wr(ADDR_PART_ID, 8'hFF);
        rd(ADDR_PART_ID, {ID_FAMILY, ID_PART_BCD});
        wr(ADDR_CLOCK_PERIOD, 8'h64);
        rd(ADDR_DATA_DELAY, 8'h19);
        wr(ADDR_DATA_DELAY, 8'h05);
        rd(ADDR_DATA_DELAY, 8'h05);
        wr(ADDR_DATA_DELAY, 8'hFF);
        rd(ADDR_DATA_DELAY, 8'h3F);
        wr(ADDR_DATA_DELAY, 8'h19);
        wr(ADDR_MODE_CONTROL, 8'h00);
        rd(ADDR_MODE_CONTROL, 8'h03);
        launch(1'b0);
        wr(ADDR_MODE_CONTROL, 8'h80);
        rd(ADDR_MODE_CONTROL, 8'h83);
        launch(1'b1);
        @(negedge pp_c);
        repeat (25) @(negedge sys_clk);
        `CMP(pp_d, 1'b1)
        @(negedge sys_clk);
        `CMP(pp_d, 1'b0)
        repeat (24) @(negedge sys_clk);
        `CMP(pp_c, 1'b0)
        @(negedge sys_clk);
        `CMP(pp_c, 1'b1)
        chan_busy = 1'b1;
        ev(1'b1, 1'b0);
        `CMP(int_n, 1'b0)
        rd(ADDR_CTRL_STATUS, 8'h24);
        `CMP(int_n, 1'b0)
        rd(ADDR_CHAN_STATUS, 8'h5C);
        `CMP(int_n, 1'b1)
        chan_busy = 1'b0;
        wr(ADDR_CTRL_IRQ_MASK, 8'h04);
        ev(1'b1, 1'b0);
        `CMP(int_n, 1'b1)
        rd(ADDR_CHAN_STATUS, 8'h5C);
        wr(ADDR_CTRL_IRQ_MASK, 8'h00);
        ev(1'b0, 1'b1);
        `CMP(int_n, 1'b0)
        rd(ADDR_CTRL_STATUS, 8'h80);
        `CMP(int_n, 1'b1)
        rd(ADDR_CTRL_STATUS, 8'h00);
        wr(ADDR_CTRL_IRQ_MASK, 8'h80);
        ev(1'b0, 1'b1);
        `CMP(int_n, 1'b1)
        rd(ADDR_CTRL_STATUS, 8'h80);
        wr(ADDR_CHAN_RESET, 8'hA5);
        rd(ADDR_CTRL_STATUS, 8'h00);
        wr(ADDR_CHAN_RESET, 8'h5A);
        `CMP(chan_reset, 1'b0)
        wr(ADDR_CHAN_RESET, 8'hA5);
        wr(ADDR_CHAN_RESET, 8'h5A);
        `CMP(chan_reset, 1'b1)
        rd(ADDR_CHAN_RESET, 8'hFF);
        repeat (30) @(negedge sys_clk);
        rd(ADDR_CHAN_RESET, 8'h00);
        rd(ADDR_CLOCK_PERIOD, 8'h20);
        rd(ADDR_CTRL_IRQ_MASK, 8'h80);
        wr(ADDR_CTRL_IRQ_MASK, 8'h84);
        wr(ADDR_GLOBAL_RESET, 8'hA5);
        wr(ADDR_GLOBAL_RESET, 8'h5B);
        rd(ADDR_CTRL_IRQ_MASK, 8'h84);
        wr(ADDR_GLOBAL_RESET, 8'hA5);
        wr(ADDR_GLOBAL_RESET, 8'h5A);
        rd(ADDR_CTRL_READY, 8'hFF);
        repeat (INIT_N) @(negedge sys_clk);
        rd(ADDR_CTRL_READY, 8'h00);
        rd(ADDR_CTRL_IRQ_MASK, 8'h00);
        report_and_stop();
    end
endmodule : ufm_regs_top_tb
bind ufm_regs_top ufm_regs_chk chk_u (.sys_clk(sys_clk), .rst(rst), .ce_n(ce_n),
    .rd_n(rd_n), .data_out(data_out), .data_oe(data_oe), .int_n(int_n),
    .buf_access(buf_access), .buf_access_ok(buf_access_ok),
    .buf_write_keep(buf_write_keep), .launch_req(launch_req), .launch_ok(launch_ok),
    .chan_reset(chan_reset), .pushpull_clock_line(pushpull_clock_line),
    .pushpull_data_line(pushpull_data_line), .od_clock_out(od_clock_out),
    .od_clock_oe(od_clock_oe), .od_data_out(od_data_out), .od_data_oe(od_data_oe));
